//--- dcru_channel_update.v
// Register update logic for a multi-channel transfer engine
//
// Notes on behaviour
// - Source address: fixed, plus offset, increment or decrement by step.
// - Destination address uses the same four update modes.
// - Access size selects step 1, 2 or 4 for both addresses.
// - Misaligned reads step per piece, then start plus full step.
// - Misaligned writes step per piece, then start plus full step.
// - Current address goes to the bus, then advances.
// - Source repeat area: restore source start when block count ends.
// - Destination repeat area: restore destination start likewise.
// - Extended area holds upper address bits fixed.
// - Byte count drops by 1, 2 or 4 per unit.
// - Byte count of zero means uncounted, left unchanged.
// - Software write wins over a same-cycle hardware update, except in the mode register.
// - Write during count-to-zero is stored, transfer still stops.
// - Block register: upper half size, lower half down-counter.
// - Block counter reloads upper half instead of reaching zero.
// - Enable clears on count end or escape stops.
// - Enable clears on error stop, reset or standby.
// - Software writing enable zero stops the channel.
// - Active flag low when idle or waiting, else high.
// - Error stop clears all enables, sets channel 0 error flag.
// - Escape flag set on escape stops; interrupt if enabled.
// - Transfer end flag set on count end; interrupt if enabled.
`include "dcru_regs.vh"

module dcru_channel_update #(
    parameter CHANNELS = 4,
    parameter CH_BITS  = 2
) (
    // Clock and reset
    input  wire                clk,
    input  wire                reset,
    // APB slave
    input  wire                psel,
    input  wire                penable,
    input  wire                pwrite,
    input  wire [11:0]         paddr,
    input  wire [31:0]         pwdata,
    output reg  [31:0]         prdata,
    output reg                 pready,
    output reg                 pslverr,
    // Transfer engine side
    input  wire [CH_BITS-1:0]  grantChannel,
    input  wire                srcAccess,
    input  wire                srcPieceLast,
    input  wire [1:0]          srcPieceSize,
    input  wire                dstAccess,
    input  wire                dstPieceLast,
    input  wire [1:0]          dstPieceSize,
    input  wire                unitDone,
    input  wire                channelBusy,
    input  wire                sizeErrorStop,
    input  wire                errorStop,
    input  wire                standby,
    // Bus address and status outputs
    output reg  [31:0]         busAddress,
    output reg  [CHANNELS-1:0] enableOut,
    output reg  [CHANNELS-1:0] irqOut
);

    // Per-channel state
    reg [31:0] srcAddrQ   [0:CHANNELS-1];
    reg [31:0] dstAddrQ   [0:CHANNELS-1];
    reg [31:0] srcStartQ  [0:CHANNELS-1];
    reg [31:0] dstStartQ  [0:CHANNELS-1];
    reg [31:0] srcRptQ    [0:CHANNELS-1];
    reg [31:0] dstRptQ    [0:CHANNELS-1];
    reg [31:0] countQ     [0:CHANNELS-1];
    reg [31:0] blockQ     [0:CHANNELS-1];
    reg [31:0] modeQ      [0:CHANNELS-1];
    reg [31:0] actlQ      [0:CHANNELS-1];
    reg [31:0] offsetQ    [0:CHANNELS-1];
    reg [31:0] areaQ      [0:CHANNELS-1];

    function [31:0] stepOf;
        input [1:0] sz;
        begin
            case (sz)
                `DCRU_SZ_WORD: stepOf = `DCRU_STEP_2;
                `DCRU_SZ_LONG: stepOf = `DCRU_STEP_4;
                default:       stepOf = `DCRU_STEP_1;
            endcase
        end
    endfunction

    // Next address from mode, 32-bit modular
    function [31:0] nextAddr;
        input [31:0] base;
        input [1:0]  mode;
        input [31:0] step;
        input [31:0] ofs;
        begin
            case (mode)
                `DCRU_AM_OFFSET: nextAddr = base + ofs;
                `DCRU_AM_INC:    nextAddr = base + step;
                `DCRU_AM_DEC:    nextAddr = base - step;
                default:         nextAddr = base;
            endcase
        end
    endfunction

    // Keep bits above the area size fixed
    function [31:0] areaKeep;
        input [31:0] oldA;
        input [31:0] newA;
        input [4:0]  bits;
        reg   [31:0] m;
        begin
            m = 32'hffffffff;
            if (bits != 5'h00) begin
                m = (32'h00000001 << bits) - 32'h00000001;
            end
            areaKeep = (bits != 5'h00) ? ((oldA & ~m) | (newA & m)) : newA;
        end
    endfunction

    wire                apbWrite = psel & penable & pwrite;
    wire [4:0]          regOff   = paddr[4:0];
    wire [CH_BITS-1:0]  regCh    = paddr[`DCRU_CH_LSB+CH_BITS-1:`DCRU_CH_LSB];
    wire                chInMap  = ({1'b0, regCh} < CHANNELS) &&
                                   (paddr[11:`DCRU_CH_LSB+CH_BITS] == 0);
    wire                gotError = errorStop;

    // Bus address from the granted channel's current value
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            busAddress <= `DCRU_ZERO32;
        end else if (srcAccess) begin
            busAddress <= srcAddrQ[grantChannel];
        end else if (dstAccess) begin
            busAddress <= dstAddrQ[grantChannel];
        end
    end

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : gCh
            wire        isGrant = (grantChannel == g);
            wire        wrHere  = apbWrite && chInMap && (regCh == g);
            wire [1:0]  sz      = {modeQ[g][`DCRU_MD_SZ_HI],
                                   modeQ[g][`DCRU_MD_SZ_LO]};
            wire [31:0] step    = stepOf(sz);
            wire [1:0]  sMode   = {actlQ[g][`DCRU_AC_SRC_HI],
                                   actlQ[g][`DCRU_AC_SRC_LO]};
            wire [1:0]  dMode   = {actlQ[g][`DCRU_AC_DST_HI],
                                   actlQ[g][`DCRU_AC_DST_LO]};
            wire        blockMd = modeQ[g][`DCRU_MD_BLOCK];
            wire        rptDst  = actlQ[g][`DCRU_AC_RPT_DST];
            wire [4:0]  sArea   = areaQ[g][`DCRU_AR_SRC_LSB+4:`DCRU_AR_SRC_LSB];
            wire [4:0]  dArea   = areaQ[g][`DCRU_AR_DST_LSB+4:`DCRU_AR_DST_LSB];
            wire        unit    = isGrant && unitDone;
            wire [15:0] blkCnt  = blockQ[g][`DCRU_BLK_HALF-1:0];
            wire [15:0] blkRld  = blockQ[g][31:`DCRU_BLK_HALF];
            // Last unit of a block: counter only moves at unit end
            wire        blkEnd  = blockMd && (blkCnt == `DCRU_ONE16);
            wire        counted = (countQ[g] != `DCRU_ZERO32);
            wire        cntEnd  = unit && counted && (countQ[g] <= step);
            wire        sPiece  = isGrant && srcAccess && !srcPieceLast;
            wire        sWhole  = isGrant && srcAccess && srcPieceLast;
            wire        dPiece  = isGrant && dstAccess && !dstPieceLast;
            wire        dWhole  = isGrant && dstAccess && dstPieceLast;
            wire        escStop = isGrant && sizeErrorStop;
            wire        sRstore = blkEnd && !rptDst;
            wire        dRstore = blkEnd && rptDst;
            reg  [31:0] sNext;
            reg  [31:0] dNext;
            reg  [31:0] sPieceNext;
            reg  [31:0] dPieceNext;

            always @* begin
                sPieceNext = (sMode == `DCRU_AM_DEC) ?
                    srcAddrQ[g] - stepOf(srcPieceSize) :
                    srcAddrQ[g] + stepOf(srcPieceSize);
                dPieceNext = (dMode == `DCRU_AM_DEC) ?
                    dstAddrQ[g] - stepOf(dstPieceSize) :
                    dstAddrQ[g] + stepOf(dstPieceSize);
                sNext = areaKeep(srcAddrQ[g],
                    nextAddr(srcRptQ[g], sMode, step, offsetQ[g]),
                    sArea);
                dNext = areaKeep(dstAddrQ[g],
                    nextAddr(dstRptQ[g], dMode, step, offsetQ[g]),
                    dArea);
            end

            always @(posedge clk or posedge reset) begin
                if (reset) begin
                    srcAddrQ[g]  <= `DCRU_ZERO32;
                    dstAddrQ[g]  <= `DCRU_ZERO32;
                    srcStartQ[g] <= `DCRU_ZERO32;
                    dstStartQ[g] <= `DCRU_ZERO32;
                    srcRptQ[g]   <= `DCRU_ZERO32;
                    dstRptQ[g]   <= `DCRU_ZERO32;
                    countQ[g]    <= `DCRU_ZERO32;
                    blockQ[g]    <= `DCRU_ZERO32;
                    modeQ[g]     <= `DCRU_ZERO32;
                    actlQ[g]     <= `DCRU_ZERO32;
                    offsetQ[g]   <= `DCRU_ZERO32;
                    areaQ[g]     <= `DCRU_ZERO32;
                end else begin
                    // Source address; CPU write wins
                    if (wrHere && regOff == `DCRU_OFF_SRC) begin
                        srcAddrQ[g]  <= pwdata;
                        srcStartQ[g] <= pwdata;
                        srcRptQ[g]   <= pwdata;
                    end else if (sPiece) begin
                        srcAddrQ[g] <= sPieceNext;
                    end else if (sWhole) begin
                        if (sRstore) begin
                            srcAddrQ[g] <= srcStartQ[g];
                            srcRptQ[g]  <= srcStartQ[g];
                        end else begin
                            srcAddrQ[g] <= sNext;
                            srcRptQ[g]  <= sNext;
                        end
                    end
                    // Destination address
                    if (wrHere && regOff == `DCRU_OFF_DST) begin
                        dstAddrQ[g]  <= pwdata;
                        dstStartQ[g] <= pwdata;
                        dstRptQ[g]   <= pwdata;
                    end else if (dPiece) begin
                        dstAddrQ[g] <= dPieceNext;
                    end else if (dWhole) begin
                        if (dRstore) begin
                            dstAddrQ[g] <= dstStartQ[g];
                            dstRptQ[g]  <= dstStartQ[g];
                        end else begin
                            dstAddrQ[g] <= dNext;
                            dstRptQ[g]  <= dNext;
                        end
                    end
                    // Byte count
                    if (wrHere && regOff == `DCRU_OFF_CNT) begin
                        countQ[g] <= pwdata;
                    end else if (unit && counted) begin
                        countQ[g] <= countQ[g] - step;
                    end
                    // Block size and down-counter
                    if (wrHere && regOff == `DCRU_OFF_BLK) begin
                        blockQ[g] <= pwdata;
                    end else if (unit && blockMd) begin
                        blockQ[g][`DCRU_BLK_HALF-1:0] <= (blkCnt == `DCRU_ONE16)
                            ? blkRld : blkCnt - `DCRU_ONE16;
                    end
                    if (wrHere && regOff == `DCRU_OFF_ACTL) begin
                        actlQ[g] <= pwdata;
                    end
                    if (wrHere && regOff == `DCRU_OFF_OFS) begin
                        offsetQ[g] <= pwdata;
                    end
                    if (wrHere && regOff == `DCRU_OFF_AREA) begin
                        areaQ[g] <= pwdata;
                    end
                    // Mode register: control fields from software
                    if (wrHere && regOff == `DCRU_OFF_MODE) begin
                        modeQ[g][`DCRU_MD_ENABLE] <= pwdata[`DCRU_MD_ENABLE];
                        modeQ[g][`DCRU_MD_SZ_LO]  <= pwdata[`DCRU_MD_SZ_LO];
                        modeQ[g][`DCRU_MD_SZ_HI]  <= pwdata[`DCRU_MD_SZ_HI];
                        modeQ[g][`DCRU_MD_BLOCK]  <= pwdata[`DCRU_MD_BLOCK];
                        modeQ[g][`DCRU_MD_ESIE]   <= pwdata[`DCRU_MD_ESIE];
                        modeQ[g][`DCRU_MD_DTIE]   <= pwdata[`DCRU_MD_DTIE];
                        // Resuming clears the end flags
                        if (pwdata[`DCRU_MD_ENABLE]) begin
                            modeQ[g][`DCRU_MD_ESCAPE_INTERRUPT_FLAG] <= 1'b0;
                            modeQ[g][`DCRU_MD_TRANSFER_END_FLAG] <= 1'b0;
                        end
                        // Error flag cleared by writing zero
                        if (!pwdata[`DCRU_MD_GLOBAL_ERROR_FLAG]) begin
                            modeQ[g][`DCRU_MD_GLOBAL_ERROR_FLAG] <= 1'b0;
                        end
                    end
                    // Hardware stops win over software enable
                    if (cntEnd) begin
                        modeQ[g][`DCRU_MD_ENABLE] <= 1'b0;
                        modeQ[g][`DCRU_MD_TRANSFER_END_FLAG]   <= 1'b1;
                    end
                    if (escStop) begin
                        modeQ[g][`DCRU_MD_ENABLE] <= 1'b0;
                        modeQ[g][`DCRU_MD_ESCAPE_INTERRUPT_FLAG]   <= 1'b1;
                    end
                    if (gotError || standby) begin
                        modeQ[g][`DCRU_MD_ENABLE] <= 1'b0;
                    end
                    if (gotError && g == 0) begin
                        modeQ[g][`DCRU_MD_GLOBAL_ERROR_FLAG] <= 1'b1;
                    end
                    modeQ[g][`DCRU_MD_ACTIVE] <= isGrant && channelBusy;
                end
            end

            // Status outputs from flops
            always @(posedge clk or posedge reset) begin
                if (reset) begin
                    enableOut[g] <= 1'b0;
                    irqOut[g]    <= 1'b0;
                end else begin
                    enableOut[g] <= modeQ[g][`DCRU_MD_ENABLE];
                    irqOut[g]    <= (modeQ[g][`DCRU_MD_ESCAPE_INTERRUPT_FLAG] &
                                     modeQ[g][`DCRU_MD_ESIE]) |
                                    (modeQ[g][`DCRU_MD_TRANSFER_END_FLAG] &
                                     modeQ[g][`DCRU_MD_DTIE]);
                end
            end
        end
    endgenerate

    // APB read and answer, one wait-free access phase
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata  <= `DCRU_ZERO32;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~chInMap;
            prdata  <= `DCRU_ZERO32;
            if (psel && !penable && !pwrite && chInMap) begin
                case (regOff)
                    `DCRU_OFF_SRC:  prdata <= srcAddrQ[regCh];
                    `DCRU_OFF_DST:  prdata <= dstAddrQ[regCh];
                    `DCRU_OFF_CNT:  prdata <= countQ[regCh];
                    `DCRU_OFF_BLK:  prdata <= blockQ[regCh];
                    `DCRU_OFF_MODE: prdata <= modeQ[regCh];
                    `DCRU_OFF_ACTL: prdata <= actlQ[regCh];
                    `DCRU_OFF_OFS:  prdata <= offsetQ[regCh];
                    `DCRU_OFF_AREA: prdata <= areaQ[regCh];
                    default:        prdata <= `DCRU_ZERO32;
                endcase
            end
        end
    end

endmodule // dcru_channel_update

//--- dcru_regs.vh
// Register map, field positions and codes of the channel update block
`ifndef DCRU_REGS_VH
`define DCRU_REGS_VH
// Register word offsets within one channel
`define DCRU_OFF_SRC      5'h00
`define DCRU_OFF_DST      5'h04
`define DCRU_OFF_CNT      5'h08
`define DCRU_OFF_BLK      5'h0c
`define DCRU_OFF_MODE     5'h10
`define DCRU_OFF_ACTL     5'h14
`define DCRU_OFF_OFS      5'h18
`define DCRU_OFF_AREA     5'h1c
// Channel stride in address bits above the channel offset
`define DCRU_CH_LSB       5
// Mode register fields
`define DCRU_MD_ENABLE    0
`define DCRU_MD_ACTIVE    1
`define DCRU_MD_GLOBAL_ERROR_FLAG      2
`define DCRU_MD_ESCAPE_INTERRUPT_FLAG      3
`define DCRU_MD_TRANSFER_END_FLAG      4
`define DCRU_MD_SZ_LO     8
`define DCRU_MD_SZ_HI     9
`define DCRU_MD_BLOCK     10
`define DCRU_MD_ESIE      11
`define DCRU_MD_DTIE      12
// Address control fields
`define DCRU_AC_SRC_LO    0
`define DCRU_AC_SRC_HI    1
`define DCRU_AC_DST_LO    2
`define DCRU_AC_DST_HI    3
`define DCRU_AC_RPT_DST   4
// Area register: source size in 4:0, destination size in 12:8
`define DCRU_AR_SRC_LSB   0
`define DCRU_AR_DST_LSB   8
// Address modes
`define DCRU_AM_FIXED     2'h0
`define DCRU_AM_OFFSET    2'h1
`define DCRU_AM_INC       2'h2
`define DCRU_AM_DEC       2'h3
// Access sizes
`define DCRU_SZ_BYTE      2'h0
`define DCRU_SZ_WORD      2'h1
`define DCRU_SZ_LONG      2'h2
// Byte steps
`define DCRU_STEP_1       32'h00000001
`define DCRU_STEP_2       32'h00000002
`define DCRU_STEP_4       32'h00000004
// Half of block register
`define DCRU_BLK_HALF     16
`define DCRU_ONE16        16'h0001
`define DCRU_ZERO32       32'h00000000
`endif

//--- dcru_channel_update_chk.sv
// Port checks for the channel register update block
module dcru_channel_update_chk #(
    parameter CHANNELS = 4,
    parameter CH_BITS  = 2
) (
    // Clock and reset
    input wire logic                clk,
    input wire logic                reset,
    // APB
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [11:0]         paddr,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    // Engine and status
    input wire logic [CH_BITS-1:0]  grantChannel,
    input wire logic                srcAccess,
    input wire logic                dstAccess,
    input wire logic                sizeErrorStop,
    input wire logic                errorStop,
    input wire logic                standby,
    input wire logic [31:0]         busAddress,
    input wire logic [CHANNELS-1:0] enableOut
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_ready_answer: assert property (
        psel && !penable |=> pready) else $error("pready missing");
    chk_ready_pulse: assert property (
        pready |-> psel && penable ##1 !pready) else $error("pready stuck");
    chk_err_ready: assert property (
        pslverr |-> pready) else $error("pslverr without pready");
    chk_unmapped_err: assert property (
        pready && paddr[11:7] != 5'h00 |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    chk_error_clear: assert property (
        errorStop |-> ##2 enableOut == '0) else $error("error stop kept enable");
    chk_standby_clear: assert property (
        standby |-> ##2 enableOut == '0) else $error("standby kept enable");
    chk_escape_clear: assert property (
        sizeErrorStop |-> ##2 !enableOut[$past(grantChannel, 2)])
        else $error("escape stop kept enable");
    chk_reset_clear: assert property (
        $fell(reset) |-> enableOut == '0) else $error("enable after reset");
    chk_addr_hold: assert property (
        !$past(srcAccess) && !$past(dstAccess) && !srcAccess && !dstAccess
        |=> $stable(busAddress)) else $error("bus address moved idle");
endmodule // dcru_channel_update_chk

bind dcru_channel_update dcru_channel_update_chk #(
    .CHANNELS(CHANNELS), .CH_BITS(CH_BITS)
) dcru_channel_update_chk_i (
    .clk, .reset, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
    .pslverr, .grantChannel, .srcAccess, .dstAccess, .sizeErrorStop,
    .errorStop, .standby, .busAddress, .enableOut
);

//--- dcru_engine_model.sv
// Transfer engine model issuing access pieces and unit completion
module dcru_engine_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Bench request
    input  wire logic       unitReq,
    input  wire logic       split,
    input  wire logic [1:0] size,
    output wire logic       done,
    // Engine pulses
    output wire logic       srcAccess,
    output wire logic       srcPieceLast,
    output wire logic [1:0] srcPieceSize,
    output wire logic       dstAccess,
    output wire logic       dstPieceLast,
    output wire logic [1:0] dstPieceSize,
    output wire logic       unitDone,
    output wire logic       channelBusy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] st_q;
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            st_q <= 3'h0;
        end else if (st_q == 3'h0) begin
            st_q <= unitReq ? (split ? 3'h1 : 3'h3) : 3'h0;
        end else begin
            st_q <= (st_q == 3'h5) ? 3'h0 : st_q + 3'h1;
        end
    end
    // Split read: byte, word, then last byte
    assign srcAccess    = st_q >= 3'h1 && st_q <= 3'h3;
    assign srcPieceLast = st_q == 3'h3;
    assign srcPieceSize = (st_q == 3'h2) ? 2'h1 : (split ? 2'h0 : size);
    assign dstAccess    = st_q == 3'h4;
    assign dstPieceLast = st_q == 3'h4;
    assign dstPieceSize = size;
    assign unitDone     = st_q == 3'h5;
    assign done         = st_q == 3'h5;
    assign channelBusy  = st_q != 3'h0;
endmodule // dcru_engine_model

//--- dcru_channel_update_bench.sv
// Testbench for the channel register update block
`include "dcru_regs.vh"
module dcru_channel_update_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, reset, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [6:0]  pg;
    logic [31:0] pwdata, prdata, busAddress, rd, step;
    logic [1:0]  grantChannel, srcPieceSize, dstPieceSize, size;
    logic        srcAccess, srcPieceLast, dstAccess, dstPieceLast, unitDone;
    logic        channelBusy, sizeErrorStop, errorStop, standby;
    logic        unitReq, split, done;
    logic [3:0]  enableOut, irqOut;
    int          err_count, comparisons, n;
    localparam logic [31:0] OFS = ~32'h10 + 32'h1;

    dcru_channel_update dcru_channel_update_i (
        .clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .grantChannel, .srcAccess, .srcPieceLast,
        .srcPieceSize, .dstAccess, .dstPieceLast, .dstPieceSize, .unitDone,
        .channelBusy, .sizeErrorStop, .errorStop, .standby, .busAddress,
        .enableOut, .irqOut
    );
    dcru_engine_model dcru_engine_model_i (
        .clk, .reset, .unitReq, .split, .size, .done, .srcAccess,
        .srcPieceLast, .srcPieceSize, .dstAccess, .dstPieceLast,
        .dstPieceSize, .unitDone, .channelBusy
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic results;
        $display("Mismatches %0d, comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic tmo;
        err_count++;
        $display("ERROR %0t wait timed out", $time);
        results();
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic wr, input logic [4:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {pg, a};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) tmo();
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cfg(input logic [31:0] s, d, c, b,
                       input logic [4:0] ac, input logic [12:0] md);
        apb(1'b1, `DCRU_OFF_MODE, 32'h0);
        apb(1'b0, `DCRU_OFF_MODE, 32'h0);
        chk1(rd[`DCRU_MD_ENABLE], 1'b0);
        apb(1'b1, `DCRU_OFF_SRC, s);
        apb(1'b1, `DCRU_OFF_DST, d);
        apb(1'b1, `DCRU_OFF_CNT, c);
        apb(1'b1, `DCRU_OFF_BLK, b);
        apb(1'b1, `DCRU_OFF_ACTL, {27'h0, ac});
        apb(1'b1, `DCRU_OFF_OFS, OFS);
        apb(1'b1, `DCRU_OFF_AREA, 32'h0);
        apb(1'b1, `DCRU_OFF_MODE, {19'h0, md});
    endtask
    task automatic unit(input logic sp);
        @(posedge clk);
        unitReq <= 1'b1;
        split <= sp;
        @(posedge clk);
        unitReq <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (done !== 1'b1 && n < 16);
        if (n >= 16) tmo();
    endtask
    function automatic logic [31:0] nxt(input logic [31:0] a,
                                        input logic [1:0] m,
                                        input logic [31:0] st);
        case (m)
            `DCRU_AM_FIXED:  return a;
            `DCRU_AM_OFFSET: return a + OFS;
            `DCRU_AM_INC:    return a + st;
            default:         return a - st;
        endcase
    endfunction

    initial begin
        {reset, psel, penable, pwrite, unitReq, split} = 6'h20;
        {sizeErrorStop, errorStop, standby} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        grantChannel = 2'h0;
        size = 2'h0;
        pg = 7'h00;
        err_count = 0;
        comparisons = 0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        apb(1'b0, `DCRU_OFF_MODE, 32'h0);
        chk32(rd, 32'h0);
        // Unmapped channel page
        pg = 7'h04;
        apb(1'b0, `DCRU_OFF_SRC, 32'h0);
        chk1(er, 1'b1);
        chk32(rd, 32'h0);
        pg = 7'h00;
        // Every address mode against every access size
        for (int m = 0; m < 4; m++) begin
            for (int s = 0; s < 3; s++) begin
                size <= s[1:0];
                step = 32'h1 << s;
                cfg(32'h100, 32'h2, (s == 1) ? 32'h0 : 32'h40, 32'h0,
                    {1'b0, 2'(3 - m), 2'(m)}, {3'h0, s[1:0], 8'h01});
                unit(1'b0);
                apb(1'b0, `DCRU_OFF_SRC, 32'h0);
                chk32(rd, nxt(32'h100, 2'(m), step));
                apb(1'b0, `DCRU_OFF_DST, 32'h0);
                chk32(rd, nxt(32'h2, 2'(3 - m), step));
                apb(1'b0, `DCRU_OFF_CNT, 32'h0);
                chk32(rd, (s == 1) ? 32'h0 : 32'h40 - step);
                chk32(busAddress, 32'h2);
            end
        end
        // Misaligned longword read
        size <= `DCRU_SZ_LONG;
        cfg(32'h101, 32'h300, 32'h0, 32'h0, 5'h0a, 13'h0201);
        unit(1'b1);
        apb(1'b0, `DCRU_OFF_SRC, 32'h0);
        chk32(rd, 32'h105);
        // Repeat area on source, block of two
        size <= `DCRU_SZ_BYTE;
        cfg(32'h200, 32'h400, 32'h0, 32'h00020002, 5'h0a, 13'h0401);
        unit(1'b0);
        apb(1'b0, `DCRU_OFF_BLK, 32'h0);
        chk32(rd, 32'h00020001);
        unit(1'b0);
        apb(1'b0, `DCRU_OFF_BLK, 32'h0);
        chk32(rd, 32'h00020002);
        apb(1'b0, `DCRU_OFF_SRC, 32'h0);
        chk32(rd, 32'h200);
        apb(1'b0, `DCRU_OFF_DST, 32'h0);
        chk32(rd, 32'h402);
        // Repeat area on destination, extended area on source
        cfg(32'h1ff, 32'h300, 32'h0, 32'h00010001, 5'h1a, 13'h0400);
        apb(1'b1, `DCRU_OFF_AREA, 32'h00000808);
        apb(1'b1, `DCRU_OFF_MODE, 32'h00000401);
        unit(1'b0);
        apb(1'b0, `DCRU_OFF_SRC, 32'h0);
        chk32(rd, 32'h100);
        apb(1'b0, `DCRU_OFF_DST, 32'h0);
        chk32(rd, 32'h300);
        // Count reaching zero ends the transfer
        size <= `DCRU_SZ_LONG;
        cfg(32'h500, 32'h600, 32'h4, 32'h0, 5'h0a, 13'h1201);
        unit(1'b0);
        apb(1'b0, `DCRU_OFF_CNT, 32'h0);
        chk32(rd, 32'h0);
        apb(1'b0, `DCRU_OFF_MODE, 32'h0);
        chk32(rd & 32'h1d, 32'h10);
        chk1(irqOut[0], 1'b1);
        // Escape, error and standby stops
        for (int k = 0; k < 3; k++) begin
            cfg(32'h700, 32'h800, 32'h0, 32'h0, 5'h0a, 13'h0a01);
            @(posedge clk);
            sizeErrorStop <= (k == 0);
            errorStop <= (k == 1);
            standby <= (k == 2);
            @(posedge clk);
            {sizeErrorStop, errorStop, standby} <= 3'h0;
            repeat (2) @(posedge clk);
            apb(1'b0, `DCRU_OFF_MODE, 32'h0);
            chk32(rd & 32'h1d,
                  (k == 0) ? 32'h08 : (k == 1) ? 32'h04 : 32'h0);
            chk1(irqOut[0], k == 0);
        end
        results();
    end
endmodule // dcru_channel_update_bench
